// >>> pkg/idm_pkg.sv
package idm_pkg;

    localparam int NUM_SFR   = 33;
    localparam int SFR_IDX_W = 6;

    // Internal data space layout
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam logic [7:0] UNDEF_READ    = 8'h00;
    localparam int         STATUS_BANK_LSB = 3;

    // Slot numbers of registers the block's own logic uses
    localparam int SLOT_PORT0   = 0;
    localparam int SLOT_STACK   = 1;
    localparam int SLOT_DP0_LO  = 2;
    localparam int SLOT_DP0_HI  = 3;
    localparam int SLOT_DP1_LO  = 4;
    localparam int SLOT_DP1_HI  = 5;
    localparam int SLOT_STRETCH = 14;
    localparam int SLOT_PORT1   = 15;
    localparam int SLOT_PTRSEL  = 16;
    localparam int SLOT_PORT2   = 23;
    localparam int SLOT_PORT3   = 27;
    localparam int SLOT_STATUS  = 32;

    // Register offsets, one per slot
    localparam logic [7:0] SFR_ADDR [NUM_SFR] = '{
        8'h80, 8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87,
        8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h90,
        8'h92, 8'h98, 8'h99, 8'h9A, 8'h9B, 8'h9C, 8'h9D, 8'hA0,
        8'hA8, 8'hA9, 8'hAA, 8'hB0, 8'hB8, 8'hB9, 8'hBA, 8'hBB,
        8'hD0
    };

    // Reset values, one per slot
    localparam logic [7:0] SFR_RESET [NUM_SFR] = '{
        8'hFF, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'hD9, 8'hFF, 8'h00, 8'h00, 8'h03, 8'h03,
        8'h00
    };

    typedef enum logic [2:0] {
        ACC_DIRECT,
        ACC_INDIRECT,
        ACC_WORKREG,
        ACC_BIT,
        ACC_PUSH,
        ACC_POP
    } idm_mode_e;

    typedef struct packed {
        logic       valid;
        logic       write;
        idm_mode_e  mode;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       bit_val;
    } idm_req_s;

    typedef struct packed {
        logic       valid;
        logic       mapped;
        logic [7:0] rdata;
        logic       bit_val;
    } idm_rsp_s;

endpackage

// >>> design/idm_data_space.sv
`timescale 1ns/1ns
// Functional notes
// - The data space has 256 bytes on one 8-bit address, reached directly or indirectly.
// - Direct and bit accesses to the upper half go to the register area, reachable no other way.
// - Indirect accesses to the upper half reach a separate 128-byte RAM block.
// - The lower 128 bytes behave the same through direct or indirect access.
// - The lowest 32 bytes are four banks of eight working registers chosen by two status bits.
// - Bytes 0x20 to 0x2F are also single-bit addressable as bit addresses 0x00 to 0x7F.
// - Reading an unimplemented register gives an undefined value; writing it changes nothing.
// - Registers at multiples of eight take bit access; others take byte access only.
// - Every register loads its listed reset value on reset.
// - Serial reload registers reset to low 0xD9, high 0x03, and second high 0x03.
// - Bank select 00 to 11 places the bank at 0x00, 0x08, 0x10 or 0x18.
// - The stack pointer is raised before a push writes, so the first byte lands at 0x08.
// - Bit 0 of the pointer select register picks data pointer 0 or 1.
module idm_data_space (
    input  wire logic              CLK,
    input  wire logic              ARST_N,
    input  wire idm_pkg::idm_req_s REQ,
    output idm_pkg::idm_rsp_s      RSP,
    output logic [1:0]             BANK_SEL,
    output logic [7:0]             STACK_PTR,
    output logic [15:0]            DATA_PTR,
    output logic [2:0]             STRETCH,
    output logic [7:0]             PORT0,
    output logic [7:0]             PORT1,
    output logic [7:0]             PORT2,
    output logic [7:0]             PORT3
);
    import idm_pkg::*;

    logic [7:0]           iram [256];
    logic [7:0]           sfr  [NUM_SFR];
    logic [7:0]           eff_addr;
    logic                 use_sfr;
    logic                 bit_op;
    logic [2:0]           bit_pos;
    logic                 stack_inc;
    logic                 stack_dec;
    logic                 sfr_hit;
    logic [SFR_IDX_W-1:0] sfr_idx;
    logic [7:0]           cur_byte;
    logic [7:0]           wr_byte;
    logic                 do_wr;
    logic                 ram_we;
    logic                 sfr_we;
    logic [1:0]           bank;
    logic [NUM_SFR-1:0]   slot_hit;
    logic [NUM_SFR-1:0]   slot_we;
    logic [7:0]           next_sfr [NUM_SFR];
    logic [7:0]           next_stack;
    logic [7:0]           merged_byte;
    logic                 is_write;
    logic                 is_push;
    logic                 is_pop;

    assign bank = sfr[SLOT_STATUS][STATUS_BANK_LSB +: 2];

    // Address steering per access mode
    always_comb begin
        eff_addr = REQ.addr;
        use_sfr  = 1'b0;
        bit_op   = 1'b0;
        bit_pos  = 3'h0;
        stack_inc = 1'b0;
        stack_dec = 1'b0;
        unique case (REQ.mode)
            ACC_DIRECT: begin
                use_sfr = REQ.addr[7];
            end
            ACC_INDIRECT: begin
                use_sfr = 1'b0;
            end
            ACC_WORKREG: begin
                eff_addr = {3'h0, bank, REQ.addr[2:0]};
            end
            ACC_BIT: begin
                bit_op  = 1'b1;
                bit_pos = REQ.addr[2:0];
                if (REQ.addr[7]) begin
                    use_sfr  = 1'b1;
                    eff_addr = {REQ.addr[7:3], 3'h0};
                end else begin
                    eff_addr = BIT_AREA_BASE | {4'h0, REQ.addr[6:3]};
                end
            end
            ACC_PUSH: begin
                eff_addr = 8'(sfr[SLOT_STACK] + 8'h01);
                stack_inc = REQ.valid;
            end
            ACC_POP: begin
                eff_addr = sfr[SLOT_STACK];
                stack_dec = REQ.valid;
            end
            default: begin
                eff_addr = REQ.addr;
            end
        endcase
    end

    // Register lookup; only listed offsets are implemented
    always_comb begin
        sfr_hit = 1'b0;
        sfr_idx = '0;
        for (int i = 0; i < NUM_SFR; i++) begin
            if (use_sfr && eff_addr == SFR_ADDR[i]) begin
                sfr_hit = 1'b1;
                sfr_idx = SFR_IDX_W'(i);
            end
        end
    end

    // Current byte, from a register or the RAM
    always_comb begin
        if (use_sfr) begin
            cur_byte = sfr_hit ? sfr[sfr_idx] : UNDEF_READ;
        end else begin
            cur_byte = iram[eff_addr];
        end
    end

    // Bit merge, one lane per bit of the byte
    generate
        for (genvar k = 0; k < 8; k++) begin : g_merge
            assign merged_byte[k] = (bit_pos == 3'(k)) ? REQ.bit_val : cur_byte[k];
        end
    endgenerate

    // Byte to write: whole byte, or the byte with one bit replaced
    always_comb begin
        wr_byte = bit_op ? merged_byte : REQ.wdata;
    end

    // Access kind decode; a pop never writes, a push always does
    always_comb begin
        is_push  = REQ.valid && (REQ.mode == ACC_PUSH);
        is_pop   = REQ.valid && (REQ.mode == ACC_POP);
        is_write = REQ.valid && REQ.write && !is_pop;
    end

    assign do_wr  = is_push || is_write;
    assign ram_we = do_wr && !use_sfr;
    assign sfr_we = do_wr && use_sfr && sfr_hit;

    // Per-slot hit and write enable
    generate
        for (genvar h = 0; h < NUM_SFR; h++) begin : g_hit
            assign slot_hit[h] = use_sfr && (eff_addr == SFR_ADDR[h]);
            assign slot_we[h]  = sfr_we && slot_hit[h];
        end
    endgenerate

    // Stack pointer next value, wrapping modulo 256
    always_comb begin
        next_stack = sfr[SLOT_STACK];
        if (stack_inc) begin
            next_stack = 8'(sfr[SLOT_STACK] + 8'h01);
        end else if (stack_dec) begin
            next_stack = 8'(sfr[SLOT_STACK] - 8'h01);
        end
    end

    // Next value per register slot
    generate
        for (genvar n = 0; n < NUM_SFR; n++) begin : g_next
            always_comb begin
                if (slot_we[n]) begin
                    next_sfr[n] = wr_byte;
                end else if (n == SLOT_STACK) begin
                    next_sfr[n] = next_stack;
                end else begin
                    next_sfr[n] = sfr[n];
                end
            end
        end
    endgenerate

    // General RAM, no reset
    always_ff @(posedge CLK) begin
        if (ram_we) begin
            iram[eff_addr] <= wr_byte;
        end
    end

    // One flip-flop byte per implemented register
    generate
        for (genvar g = 0; g < NUM_SFR; g++) begin : g_sfr
            always_ff @(posedge CLK or negedge ARST_N) begin
                if (!ARST_N) begin
                    sfr[g] <= SFR_RESET[g];
                end else begin
                    sfr[g] <= next_sfr[g];
                end
            end
        end
    endgenerate

    // Registered answer, one cycle after the request
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            RSP <= '0;
        end else begin
            RSP.valid   <= REQ.valid;
            RSP.mapped  <= REQ.valid && (!use_sfr || sfr_hit);
            RSP.rdata   <= REQ.valid ? cur_byte : 8'h00;
            RSP.bit_val <= REQ.valid && cur_byte[bit_pos];
        end
    end

    // Active data pointer, registered copy
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            DATA_PTR <= 16'h0000;
        end else if (sfr[SLOT_PTRSEL][0]) begin
            DATA_PTR <= {sfr[SLOT_DP1_HI], sfr[SLOT_DP1_LO]};
        end else begin
            DATA_PTR <= {sfr[SLOT_DP0_HI], sfr[SLOT_DP0_LO]};
        end
    end

    assign BANK_SEL  = bank;
    assign STACK_PTR = sfr[SLOT_STACK];
    assign STRETCH   = sfr[SLOT_STRETCH][2:0];
    assign PORT0     = sfr[SLOT_PORT0];
    assign PORT1     = sfr[SLOT_PORT1];
    assign PORT2     = sfr[SLOT_PORT2];
    assign PORT3     = sfr[SLOT_PORT3];

endmodule // idm_data_space

// >>> testbench/idm_core_model.sv
`timescale 1ns/1ns
module idm_core_model (
    input  wire idm_pkg::idm_rsp_s RSP,
    input  wire logic              CLK,
    output idm_pkg::idm_req_s      REQ
);
    import idm_pkg::*;
    logic last_bit;
    initial REQ = '0;
    // Request held through its taking edge, answer read one cycle later
    task automatic acc(input logic w, input idm_mode_e m, input logic [7:0] a, d,
                       input logic b, output logic [7:0] q, output logic mp);
        @(negedge CLK);
        REQ <= '{1'b1, w, m, a, d, b};
        @(posedge CLK);
        @(negedge CLK);
        q = RSP.rdata;
        mp = RSP.mapped;
        last_bit = RSP.bit_val;
        REQ <= '0;
    endtask
endmodule // idm_core_model

// >>> testbench/idm_checker.sv
`timescale 1ns/1ns
module idm_checker (
    input wire logic              CLK,
    input wire logic              ARST_N,
    input wire idm_pkg::idm_req_s REQ,
    input wire idm_pkg::idm_rsp_s RSP,
    input wire logic [7:0]        STACK_PTR,
    input wire logic [7:0]        PORT0
);
    import idm_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    sequence s_push;
        REQ.valid && REQ.mode == ACC_PUSH;
    endsequence
    sequence s_pop;
        REQ.valid && REQ.mode == ACC_POP;
    endsequence
    a_answer_next: assert property (REQ.valid |=> RSP.valid)
        else $error("no answer");
    a_no_spurious: assert property (!REQ.valid |=> !RSP.valid && RSP.rdata == 8'h00)
        else $error("spurious answer");
    a_push_raise: assert property (s_push |=> STACK_PTR == $past(STACK_PTR) + 8'h01)
        else $error("push pointer");
    a_pop_lower: assert property (s_pop |=> STACK_PTR == $past(STACK_PTR) - 8'h01)
        else $error("pop pointer");
    a_undef_zero: assert property (RSP.valid && !RSP.mapped |-> RSP.rdata == UNDEF_READ)
        else $error("unmapped read");
    a_indirect_ram: assert property (REQ.valid && REQ.mode == ACC_INDIRECT |=> RSP.mapped)
        else $error("indirect unmapped");
    a_lower_mapped: assert property (REQ.valid && REQ.mode == ACC_DIRECT && !REQ.addr[7]
        |=> RSP.mapped) else $error("lower unmapped");
    a_port_hold: assert property (!(REQ.valid && REQ.write) |=> $stable(PORT0))
        else $error("port changed");
endmodule // idm_checker
bind idm_data_space idm_checker u_chk (.CLK(CLK), .ARST_N(ARST_N), .REQ(REQ), .RSP(RSP),
    .STACK_PTR(STACK_PTR), .PORT0(PORT0));

// >>> testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import idm_pkg::*;
    logic        CLK;
    logic        ARST_N;
    idm_req_s    req;
    idm_rsp_s    rsp;
    logic [1:0]  bank;
    logic [2:0]  stretch;
    logic [7:0]  stack_ptr, port0, port1, port2, port3, q;
    logic [15:0] dp;
    logic        mp;
    int          n_errors = 0;
    int          checks_done = 0;
    idm_data_space uut (.CLK(CLK), .ARST_N(ARST_N), .REQ(req), .RSP(rsp), .BANK_SEL(bank),
        .STACK_PTR(stack_ptr), .DATA_PTR(dp), .STRETCH(stretch), .PORT0(port0),
        .PORT1(port1), .PORT2(port2), .PORT3(port3));
    idm_core_model cpu (.RSP(rsp), .CLK(CLK), .REQ(req));
    initial begin
        CLK = 1'b0;
        forever #10 CLK = ~CLK;
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input idm_mode_e m, input logic [7:0] a, d);
        cpu.acc(1'b1, m, a, d, 1'b0, q, mp);
    endtask
    task automatic rc(input idm_mode_e m, input logic [7:0] a, e);
        cpu.acc(1'b0, m, a, 8'h00, 1'b0, q, mp);
        chk("rdata", {8'h00, e}, {8'h00, q});
    endtask
    task results;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        results;
    end
    initial begin
        ARST_N = 1'b0;
        repeat (8) @(posedge CLK);
        @(negedge CLK) ARST_N = 1'b1;
        rc(ACC_DIRECT, 8'h80, 8'hFF);
        rc(ACC_DIRECT, 8'h81, 8'h07);
        rc(ACC_DIRECT, 8'h8E, 8'h01);
        rc(ACC_DIRECT, 8'hB0, 8'hFF);
        rc(ACC_DIRECT, 8'hA0, 8'h00);
        rc(ACC_DIRECT, 8'hAA, 8'hD9);
        rc(ACC_DIRECT, 8'hBA, 8'h03);
        rc(ACC_DIRECT, 8'hBB, 8'h03);
        chk("stretch", 16'h0001, {13'h0, stretch});
        chk("port0", 16'h00FF, {8'h00, port0});
        chk("port2", 16'h0000, {8'h00, port2});
        chk("port3", 16'h00FF, {8'h00, port3});
        wr(ACC_DIRECT, 8'hC8, 8'h55);
        chk("mapped", 16'h0000, {15'h0, mp});
        rc(ACC_DIRECT, 8'hC8, 8'h00);
        wr(ACC_DIRECT, 8'h90, 8'h5A);
        wr(ACC_INDIRECT, 8'h90, 8'hA5);
        rc(ACC_DIRECT, 8'h90, 8'h5A);
        rc(ACC_INDIRECT, 8'h90, 8'hA5);
        chk("port1", 16'h005A, {8'h00, port1});
        wr(ACC_DIRECT, 8'h30, 8'h3C);
        rc(ACC_INDIRECT, 8'h30, 8'h3C);
        wr(ACC_INDIRECT, 8'h7F, 8'hC3);
        rc(ACC_DIRECT, 8'h7F, 8'hC3);
        for (int b = 0; b < 4; b++) begin
            wr(ACC_DIRECT, 8'hD0, 8'(b << 3));
            wr(ACC_WORKREG, 8'h02, 8'(8'h40 + b));
            chk("bank", 16'(b), {14'h0, bank});
        end
        for (int b = 0; b < 4; b++) begin
            rc(ACC_INDIRECT, 8'(b * 8 + 2), 8'(8'h40 + b));
        end
        wr(ACC_DIRECT, 8'h21, 8'h00);
        cpu.acc(1'b1, ACC_BIT, 8'h0B, 8'h00, 1'b1, q, mp);
        rc(ACC_DIRECT, 8'h21, 8'h08);
        cpu.acc(1'b0, ACC_BIT, 8'h0B, 8'h00, 1'b0, q, mp);
        chk("bit", 16'h0001, {15'h0, cpu.last_bit});
        cpu.acc(1'b1, ACC_BIT, 8'h91, 8'h00, 1'b0, q, mp);
        rc(ACC_DIRECT, 8'h90, 8'h58);
        wr(ACC_PUSH, 8'h00, 8'hAA);
        chk("stack_ptr", 16'h0008, {8'h00, stack_ptr});
        rc(ACC_DIRECT, 8'h81, 8'h08);
        rc(ACC_INDIRECT, 8'h08, 8'hAA);
        rc(ACC_POP, 8'h00, 8'hAA);
        rc(ACC_DIRECT, 8'h81, 8'h07);
        wr(ACC_DIRECT, 8'h82, 8'h11);
        wr(ACC_DIRECT, 8'h84, 8'h22);
        repeat (2) @(negedge CLK);
        chk("dptr", 16'h0011, dp);
        wr(ACC_DIRECT, 8'h92, 8'h01);
        repeat (2) @(negedge CLK);
        chk("dptr", 16'h0022, dp);
        results;
    end
endmodule // tb_top
